// ### adcs_area_dec.sv
`timescale 1ns/1ps
`include "adcs_defines.svh"

module adcs_area_dec #(
   parameter bit ROM_IS_32K = 1'b0
) (
   input  wire logic [27:0]       addr_i,
   input  wire logic [2:0]        boot_mode_pins_i,
   input  wire logic              dram_area_enable_i,
   input  wire logic              row_col_mux_enable_i,
   input  wire logic              muxed_io_enable_i,
   output adcs_pkg::adcs_dec_s    dec_o
);

   wire logic        a27      = addr_i[27];
   wire logic [23:0] ext_phys = {2'h0, addr_i[21:0]};
   wire logic [23:0] rom_phys = ROM_IS_32K ? {9'h000, addr_i[14:0]} : {10'h000, addr_i[13:0]};

   always_comb begin
      dec_o           = '0;
      dec_o.area      = addr_i[26:24];
      dec_o.space     = adcs_pkg::ADCS_SP_EXT;
      dec_o.width     = a27 ? adcs_pkg::ADCS_W16 : adcs_pkg::ADCS_W8;
      dec_o.off_chip  = 1'b1;
      dec_o.cs_en     = 1'b1;
      dec_o.phys      = ext_phys;
      case (addr_i[26:24])
         3'h0: begin
            dec_o.long_wait = 1'b1;
            if (boot_mode_pins_i == `ADCS_MODE_ROM) begin
               dec_o.space     = adcs_pkg::ADCS_SP_ROM;
               dec_o.width     = adcs_pkg::ADCS_W32;
               dec_o.off_chip  = 1'b0;
               dec_o.cs_en     = 1'b0;
               dec_o.long_wait = 1'b0;
               dec_o.phys      = rom_phys;
            end else if (boot_mode_pins_i == `ADCS_MODE_EXT16) begin
               dec_o.width = adcs_pkg::ADCS_W16;
            end else begin
               dec_o.width = adcs_pkg::ADCS_W8;
            end
         end
         3'h1: begin
            if (dram_area_enable_i) begin
               dec_o.space    = adcs_pkg::ADCS_SP_DRAM;
               dec_o.cs_en    = 1'b0;
               dec_o.dram_mux = row_col_mux_enable_i;
               if (row_col_mux_enable_i) begin
                  dec_o.phys = addr_i[23:0];
               end
            end
         end
         3'h2: begin
            dec_o.long_wait = 1'b1;
         end
         3'h5: begin
            if (!a27) begin
               dec_o.space    = adcs_pkg::ADCS_SP_PERI;
               dec_o.width    = addr_i[8] ? adcs_pkg::ADCS_W16 : adcs_pkg::ADCS_W8;
               dec_o.off_chip = 1'b0;
               dec_o.cs_en    = 1'b0;
               dec_o.phys     = {15'h0000, addr_i[8:0]};
            end
         end
         3'h6: begin
            if (!a27) begin
               dec_o.width = addr_i[14] ? adcs_pkg::ADCS_W16 : adcs_pkg::ADCS_W8;
            end
            if (!a27 && muxed_io_enable_i) begin
               dec_o.space = adcs_pkg::ADCS_SP_MUXIO;
            end else begin
               dec_o.long_wait = 1'b1;
               dec_o.lw_area6  = 1'b1;
            end
         end
         3'h7: begin
            if (a27) begin
               dec_o.space    = adcs_pkg::ADCS_SP_RAM;
               dec_o.width    = adcs_pkg::ADCS_W32;
               dec_o.off_chip = 1'b0;
               dec_o.cs_en    = 1'b0;
               dec_o.phys     = {14'h0000, addr_i[9:0]};
            end
         end
         default: begin
            dec_o.long_wait = 1'b0;
         end
      endcase
   end

endmodule : adcs_area_dec

// ### adcs_area_decode_chip_select.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "adcs_defines.svh"

// Operation
// - A26-A24 pick area, its select goes low.
// - No select for on-chip ROM, peripherals, RAM.
// - A23/A22 not driven; 4 Mbyte shadows.
// - In areas 0-4 both A27 halves reach the same space.
// - Boot pins set area 0 type, width.
// - ROM ignores upper bits, no area 0 select.
// - Areas 0 (except ROM boot), 2 get 1-4 long waits.
// - DRAM enable low makes area 1 external.
// - Areas 1-4 width from A27, select asserted except for DRAM in area 1.
// - DRAM mux drives A23-A0 on A11-A0, no select.
// - Area 5 low half is peripherals, A8 width.
// - Area 5 high half is 16-bit external.
// - Area 6 low half muxed I/O or external.
// - Muxed I/O width from A14, select asserted.
// - Area 6 external: A14 width in low half, 16-bit in high half, own long wait.
// - Area 7 low half is 8-bit external.
// - Area 7 high half is 1 kbyte RAM.
// - A31-A28 ignored and never driven.
module adcs_area_decode_chip_select #(
   parameter bit ROM_IS_32K = 1'b0
) (
   input  wire logic                 mclk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic [3:0]           reg_addr_i,
   input  wire logic [7:0]           reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   output wire logic [7:0]           reg_rdata_o,
   input  wire logic [2:0]           boot_mode_pins_i,
   input  wire logic                 acc_req_i,
   input  wire logic [31:0]          acc_addr_i,
   output wire logic                 acc_ready_o,
   output wire logic                 cycle_done_o,
   output wire logic [7:0]           area_select_n_o,
   output wire logic [23:0]          pin_addr_o,
   output wire logic                 dram_col_phase_o,
   output wire adcs_pkg::adcs_space_e space_o,
   output wire adcs_pkg::adcs_width_e bus_width_o,
   output wire logic [2:0]           long_wait_states_o
);

   function automatic logic [7:0] sel_for(input logic [2:0] area);
      sel_for = ~(8'h01 << area);
   endfunction : sel_for

   // Mode pins are straps from outside and pass two flip-flops first.
   logic [2:0] mode_s1_q;
   logic [2:0] mode_s2_q;

   logic [7:0]              bcr_q;
   logic [7:0]              dcr_q;
   logic [7:0]              lwc_q;
   logic [7:0]              rdata_q;
   adcs_pkg::adcs_state_e   state_q;
   adcs_pkg::adcs_state_e   state_d;
   adcs_pkg::adcs_dec_s     dec;
   adcs_pkg::adcs_dec_s     dec_q;
   logic [7:0]              sel_q;
   logic [7:0]              sel_d;
   logic [23:0]             addr_q;
   logic [23:0]             addr_d;
   logic [2:0]              lw_states_q;

   wire logic dram_area_enable   = bcr_q[`ADCS_BCR_DRAM_BIT];
   wire logic muxed_io_enable    = bcr_q[`ADCS_BCR_IO_BIT];
   wire logic row_col_mux_enable = dcr_q[`ADCS_DCR_MUX_BIT];
   wire logic [1:0] area02_long_wait = lwc_q[`ADCS_LW02_LSB+1:`ADCS_LW02_LSB];
   wire logic [1:0] area6_long_wait  = lwc_q[`ADCS_LW6_LSB+1:`ADCS_LW6_LSB];

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mode_s1_q <= 3'h0;
         mode_s2_q <= 3'h0;
      end else begin
         mode_s1_q <= boot_mode_pins_i;
         mode_s2_q <= mode_s1_q;
      end
   end

   // Register port: writes take effect at the next edge, reads answer one cycle later.
   wire logic wr_bcr = reg_wr_i && reg_addr_i == `ADCS_OFF_BUS_CTRL;
   wire logic wr_dcr = reg_wr_i && reg_addr_i == `ADCS_OFF_DRAM_CTRL;
   wire logic wr_lwc = reg_wr_i && reg_addr_i == `ADCS_OFF_LW_CFG;
   wire logic [7:0] status_val = {3'h0, state_q, dec_q.space};
   wire logic [7:0] rd_val =
      (reg_addr_i == `ADCS_OFF_BUS_CTRL)  ? {6'h00, bcr_q[1:0]} :
      (reg_addr_i == `ADCS_OFF_DRAM_CTRL) ? {7'h00, dcr_q[0]} :
      (reg_addr_i == `ADCS_OFF_LW_CFG)    ? {4'h0, lwc_q[3:0]} :
      (reg_addr_i == `ADCS_OFF_STATUS)    ? status_val : 8'h00;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         bcr_q   <= `ADCS_BCR_RST;
         dcr_q   <= `ADCS_DCR_RST;
         lwc_q   <= `ADCS_LW_RST;
         rdata_q <= 8'h00;
      end else begin
         if (wr_bcr) begin
            bcr_q <= {6'h00, reg_wdata_i[1:0]};
         end
         if (wr_dcr) begin
            dcr_q <= {7'h00, reg_wdata_i[0]};
         end
         if (wr_lwc) begin
            lwc_q <= {4'h0, reg_wdata_i[3:0]};
         end
         rdata_q <= reg_rd_i ? rd_val : 8'h00;
      end
   end

   // Only A27-A0 enter the decoder; the top nibble has no effect anywhere.
   adcs_area_dec #(
      .ROM_IS_32K (ROM_IS_32K)
   ) u_dec (
      .addr_i               (acc_addr_i[27:0]),
      .boot_mode_pins_i     (mode_s2_q),
      .dram_area_enable_i   (dram_area_enable),
      .row_col_mux_enable_i (row_col_mux_enable),
      .muxed_io_enable_i    (muxed_io_enable),
      .dec_o                (dec)
   );

   wire logic start   = (state_q == adcs_pkg::ADCS_ST_IDLE) && acc_req_i;
   wire logic in_t1   = (state_q == adcs_pkg::ADCS_ST_T1);
   wire logic in_lw   = (state_q == adcs_pkg::ADCS_ST_LW);
   wire logic in_col  = (state_q == adcs_pkg::ADCS_ST_COL);
   wire logic to_col  = in_t1 && dec_q.space == adcs_pkg::ADCS_SP_DRAM && dec_q.dram_mux;
   wire logic to_lw   = in_t1 && !to_col && dec_q.long_wait;
   wire logic lw_zero;
   wire logic last    = (in_t1 && !to_col && !to_lw) || (in_lw && lw_zero) || in_col;
   wire logic [1:0] lw_field = dec.lw_area6 ? area6_long_wait : area02_long_wait;

   adcs_wait_cnt #(
      .W (2)
   ) u_wait (
      .mclk_i     (mclk_i),
      .sys_rst_i  (sys_rst_i),
      .load_i     (start),
      .load_val_i (lw_field),
      .dec_i      (in_lw),
      .zero_o     (lw_zero)
   );

   always_comb begin
      state_d = state_q;
      case (state_q)
         adcs_pkg::ADCS_ST_IDLE: begin
            if (acc_req_i) begin
               state_d = adcs_pkg::ADCS_ST_T1;
            end
         end
         adcs_pkg::ADCS_ST_T1: begin
            if (to_col) begin
               state_d = adcs_pkg::ADCS_ST_COL;
            end else if (to_lw) begin
               state_d = adcs_pkg::ADCS_ST_LW;
            end else begin
               state_d = adcs_pkg::ADCS_ST_IDLE;
            end
         end
         adcs_pkg::ADCS_ST_LW: begin
            if (lw_zero) begin
               state_d = adcs_pkg::ADCS_ST_IDLE;
            end
         end
         adcs_pkg::ADCS_ST_COL: begin
            state_d = adcs_pkg::ADCS_ST_IDLE;
         end
         default: begin
            state_d = adcs_pkg::ADCS_ST_IDLE;
         end
      endcase
   end

   // Selects fall only for areas the decoder marks as select-carrying.
   wire logic [7:0] sel_start = dec.cs_en ? sel_for(dec.area) : `ADCS_SEL_IDLE;
   assign sel_d = start ? sel_start : (last ? `ADCS_SEL_IDLE : sel_q);

   // Multiplexed DRAM puts the row half out first, then the column half.
   wire logic [23:0] row_addr = {12'h000, dec.phys[23:12]};
   wire logic [23:0] col_addr = {12'h000, dec_q.phys[11:0]};
   assign addr_d = start ? (dec.dram_mux ? row_addr : dec.phys) :
                   (to_col ? col_addr : addr_q);

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_q     <= adcs_pkg::ADCS_ST_IDLE;
         dec_q       <= '0;
         sel_q       <= `ADCS_SEL_IDLE;
         addr_q      <= 24'h000000;
         lw_states_q <= 3'h0;
      end else begin
         state_q <= state_d;
         sel_q   <= sel_d;
         addr_q  <= addr_d;
         if (start) begin
            dec_q       <= dec;
            lw_states_q <= dec.long_wait ? {1'b0, lw_field} + 3'h1 : 3'h0;
         end
      end
   end

   assign reg_rdata_o        = rdata_q;
   assign acc_ready_o        = (state_q == adcs_pkg::ADCS_ST_IDLE);
   assign cycle_done_o       = last;
   assign area_select_n_o    = sel_q;
   assign pin_addr_o         = addr_q;
   assign dram_col_phase_o   = in_col;
   assign space_o            = dec_q.space;
   assign bus_width_o        = dec_q.width;
   assign long_wait_states_o = lw_states_q;

   // Cycles spent in the long-wait state, for checking only.
   logic [2:0] lw_run_q;
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !in_lw) begin
         lw_run_q <= 3'h0;
      end else begin
         lw_run_q <= lw_run_q + 3'h1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   sel_onehot_a: assert property ($countones(~area_select_n_o) <= 1)
      else $error("more than one area select low");
   sel_idle_a: assert property (acc_ready_o |-> area_select_n_o == 8'hff)
      else $error("area select low while idle");
   sel_area_a: assert property (start && dec.cs_en |=>
         area_select_n_o == sel_for($past(acc_addr_i[26:24])))
      else $error("wrong area select for decoded area");
   onchip_nosel_a: assert property (!acc_ready_o && !dec_q.off_chip |->
         area_select_n_o == 8'hff)
      else $error("select low for on-chip access");
   shadow_bits_a: assert property (!acc_ready_o && dec_q.off_chip && !dec_q.dram_mux |->
         pin_addr_o[23:22] == 2'h0)
      else $error("A23 or A22 driven outside muxed DRAM");
   boot_rom_a: assert property (start && acc_addr_i[26:24] == 3'h0 &&
         mode_s2_q == `ADCS_MODE_ROM |=> space_o == adcs_pkg::ADCS_SP_ROM &&
         bus_width_o == adcs_pkg::ADCS_W32 && pin_addr_o[23:15] == 9'h000)
      else $error("area 0 not on-chip ROM in ROM boot mode");
   boot_ext16_a: assert property (start && acc_addr_i[26:24] == 3'h0 &&
         mode_s2_q == `ADCS_MODE_EXT16 |=> bus_width_o == adcs_pkg::ADCS_W16 &&
         area_select_n_o == 8'hfe)
      else $error("area 0 not 16-bit external");
   lw_length_a: assert property (in_lw && lw_zero |->
         lw_run_q + 3'h1 == lw_states_q && lw_states_q >= 3'h1)
      else $error("long-wait count differs from setting");
   area1_ext_a: assert property (start && acc_addr_i[26:24] == 3'h1 && !dram_area_enable |=>
         area_select_n_o == 8'hfd)
      else $error("area 1 external without its select");
   width_a27_a: assert property (start && acc_addr_i[26:24] inside {3'h1, 3'h2, 3'h3, 3'h4} |=>
         bus_width_o == ($past(acc_addr_i[27]) ? adcs_pkg::ADCS_W16 : adcs_pkg::ADCS_W8) &&
         pin_addr_o[21:0] == $past(acc_addr_i[21:0]) || space_o == adcs_pkg::ADCS_SP_DRAM)
      else $error("width or address wrong for areas 1 to 4");
   dram_col_a: assert property (to_col |=> dram_col_phase_o &&
         pin_addr_o == {12'h000, $past(dec_q.phys[11:0])} && area_select_n_o == 8'hff)
      else $error("DRAM column phase wrong");
   peri_a: assert property (start && acc_addr_i[26:24] == 3'h5 && !acc_addr_i[27] |=>
         space_o == adcs_pkg::ADCS_SP_PERI && pin_addr_o[23:9] == 15'h0000 &&
         bus_width_o == ($past(acc_addr_i[8]) ? adcs_pkg::ADCS_W16 : adcs_pkg::ADCS_W8))
      else $error("peripheral space decoded wrongly");
   area5_ext_a: assert property (start && acc_addr_i[27:24] == 4'hd |=>
         bus_width_o == adcs_pkg::ADCS_W16 && area_select_n_o == 8'hdf)
      else $error("area 5 upper half not 16-bit external");
   muxio_a: assert property (start && acc_addr_i[27:24] == 4'h6 && muxed_io_enable |=>
         space_o == adcs_pkg::ADCS_SP_MUXIO && area_select_n_o == 8'hbf &&
         bus_width_o == ($past(acc_addr_i[14]) ? adcs_pkg::ADCS_W16 : adcs_pkg::ADCS_W8))
      else $error("muxed I/O space decoded wrongly");
   area6_ext_a: assert property (start && acc_addr_i[27:24] == 4'h6 && !muxed_io_enable |=>
         space_o == adcs_pkg::ADCS_SP_EXT && long_wait_states_o == {1'b0, area6_long_wait} + 3'h1)
      else $error("area 6 external long wait wrong");
   area7_a: assert property (start && acc_addr_i[26:24] == 3'h7 |=>
         (space_o == adcs_pkg::ADCS_SP_RAM) == $past(acc_addr_i[27]) &&
         (area_select_n_o == 8'h7f) == !$past(acc_addr_i[27]))
      else $error("area 7 decoded wrongly");
   ram_mirror_a: assert property (!acc_ready_o && space_o == adcs_pkg::ADCS_SP_RAM |->
         pin_addr_o[23:10] == 14'h0000 && bus_width_o == adcs_pkg::ADCS_W32)
      else $error("on-chip RAM offset not mirrored");
   top_nibble_a: assert property (start |=>
         dec_q.area == $past(acc_addr_i[26:24]))
      else $error("area taken from wrong address bits");
   ext_shadow_a: assert property (start && dec.off_chip && !dec.dram_mux |=>
         pin_addr_o == {2'h0, $past(acc_addr_i[21:0])})
      else $error("external address not folded to 4 Mbyte");
   dram_row_a: assert property (start && dec.dram_mux |=>
         pin_addr_o == {12'h000, $past(acc_addr_i[23:12])})
      else $error("DRAM row address wrong");
   dram_nosel_a: assert property (!acc_ready_o && space_o == adcs_pkg::ADCS_SP_DRAM |->
         area_select_n_o == 8'hff)
      else $error("area 1 select low during DRAM access");
   done_idle_a: assert property (cycle_done_o |=>
         acc_ready_o && area_select_n_o == 8'hff)
      else $error("selects not released after last cycle");

endmodule : adcs_area_decode_chip_select

// ### adcs_defines.svh
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH

// Register offsets on the plain register port.
`define ADCS_OFF_BUS_CTRL  4'h0
`define ADCS_OFF_DRAM_CTRL 4'h4
`define ADCS_OFF_LW_CFG    4'h8
`define ADCS_OFF_STATUS    4'hc

// Field positions.
`define ADCS_BCR_DRAM_BIT  0
`define ADCS_BCR_IO_BIT    1
`define ADCS_DCR_MUX_BIT   0
`define ADCS_LW02_LSB      0
`define ADCS_LW6_LSB       2

// Reset values.
`define ADCS_BCR_RST       8'h00
`define ADCS_DCR_RST       8'h00
`define ADCS_LW_RST        8'h0f
`define ADCS_SEL_IDLE      8'hff

// Boot mode pin codes.
`define ADCS_MODE_EXT8     3'h0
`define ADCS_MODE_EXT16    3'h1
`define ADCS_MODE_ROM      3'h2

`endif

// ### adcs_mem_partner.sv
`timescale 1ns/1ps

// Stands in for the external memories hanging off the area selects.
// It remembers which area last saw its select low and flags any cycle
// in which two memories would have driven the shared bus at once.
module adcs_mem_partner (
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [7:0] area_select_n_i,
   output logic [2:0]      last_area_o,
   output logic            multi_o
);
   wire logic [3:0] n_low = 4'(8 - $countones(area_select_n_i));

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         last_area_o <= 3'h0;
         multi_o     <= 1'b0;
      end else begin
         if (n_low > 4'h1) multi_o <= 1'b1;
         for (int i = 0; i < 8; i++) begin
            if (area_select_n_i[i] == 1'b0) last_area_o <= 3'(i);
         end
      end
   end
endmodule : adcs_mem_partner

// ### adcs_pkg.sv
package adcs_pkg;

   typedef enum logic [2:0] {
      ADCS_SP_EXT   = 3'b000,
      ADCS_SP_ROM   = 3'b001,
      ADCS_SP_PERI  = 3'b010,
      ADCS_SP_RAM   = 3'b011,
      ADCS_SP_DRAM  = 3'b100,
      ADCS_SP_MUXIO = 3'b101
   } adcs_space_e;

   typedef enum logic [1:0] {
      ADCS_W8  = 2'b00,
      ADCS_W16 = 2'b01,
      ADCS_W32 = 2'b10
   } adcs_width_e;

   typedef enum logic [1:0] {
      ADCS_ST_IDLE = 2'b00,
      ADCS_ST_T1   = 2'b01,
      ADCS_ST_LW   = 2'b10,
      ADCS_ST_COL  = 2'b11
   } adcs_state_e;

   typedef struct packed {
      logic [2:0]  area;
      adcs_space_e space;
      adcs_width_e width;
      logic        off_chip;
      logic        cs_en;
      logic        long_wait;
      logic        lw_area6;
      logic        dram_mux;
      logic [23:0] phys;
   } adcs_dec_s;

endpackage : adcs_pkg

// ### adcs_wait_cnt.sv
`timescale 1ns/1ps

module adcs_wait_cnt #(
   parameter int W = 2
) (
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   input  wire logic         dec_i,
   output wire logic         zero_o
);

   logic [W-1:0] cnt_q;

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= load_val_i;
      end else if (dec_i && cnt_q != '0) begin
         cnt_q <= cnt_q - W'(1);
      end
   end

   assign zero_o = (cnt_q == '0);

endmodule : adcs_wait_cnt

// ### test_adcs_area_decode_chip_select.sv
`timescale 1ns/1ps

module test_adcs_area_decode_chip_select;
   localparam logic [2:0] sp_ext  = adcs_pkg::ADCS_SP_EXT;
   localparam logic [2:0] sp_rom  = adcs_pkg::ADCS_SP_ROM;
   localparam logic [2:0] sp_peri = adcs_pkg::ADCS_SP_PERI;
   localparam logic [2:0] sp_ram  = adcs_pkg::ADCS_SP_RAM;
   localparam logic [2:0] sp_dram = adcs_pkg::ADCS_SP_DRAM;
   localparam logic [2:0] sp_mux  = adcs_pkg::ADCS_SP_MUXIO;
   localparam logic [1:0] w8      = adcs_pkg::ADCS_W8;
   localparam logic [1:0] w16     = adcs_pkg::ADCS_W16;
   localparam logic [1:0] w32     = adcs_pkg::ADCS_W32;

   logic                  mclk_i = 1'b0;
   logic                  sys_rst_i = 1'b1;
   logic [3:0]            reg_addr_i = 4'h0;
   logic [7:0]            reg_wdata_i = 8'h00;
   logic                  reg_wr_i = 1'b0;
   logic                  reg_rd_i = 1'b0;
   logic [2:0]            boot_mode_pins_i = 3'h0;
   logic                  acc_req_i = 1'b0;
   logic [31:0]           acc_addr_i = 32'h0;
   logic                  mux_on = 1'b0;
   wire logic [7:0]       reg_rdata_o;
   wire logic             acc_ready_o;
   wire logic             cycle_done_o;
   wire logic [7:0]       area_select_n_o;
   wire logic [23:0]      pin_addr_o;
   wire logic             dram_col_phase_o;
   adcs_pkg::adcs_space_e space_o;
   adcs_pkg::adcs_width_e bus_width_o;
   wire logic [2:0]       long_wait_states_o;
   wire logic [2:0]       last_area;
   wire logic             multi;
   int                    n_fail = 0;
   int                    n_compared = 0;

   always #2 mclk_i = ~mclk_i;

   adcs_area_decode_chip_select adcs_area_decode_chip_select_i (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .boot_mode_pins_i(boot_mode_pins_i),
      .acc_req_i(acc_req_i), .acc_addr_i(acc_addr_i), .acc_ready_o(acc_ready_o),
      .cycle_done_o(cycle_done_o), .area_select_n_o(area_select_n_o),
      .pin_addr_o(pin_addr_o), .dram_col_phase_o(dram_col_phase_o),
      .space_o(space_o), .bus_width_o(bus_width_o),
      .long_wait_states_o(long_wait_states_o)
   );

   adcs_mem_partner adcs_mem_partner_i (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .area_select_n_i(area_select_n_o),
      .last_area_o(last_area), .multi_o(multi)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1;
      check(reg_rdata_o, exp);
   endtask : reg_read

   task automatic set_boot(input logic [2:0] m);
      @(posedge mclk_i);
      boot_mode_pins_i <= m;
      repeat (4) @(posedge mclk_i);
   endtask : set_boot

   // Expected select and pin address are derived here from the space,
   // so every call only names what the area is supposed to become.
   task automatic acc(input logic [31:0] a, input logic [2:0] sp, input logic [1:0] w,
                      input logic [2:0] lw);
      logic [23:0] pin;
      logic [7:0]  sel;
      int          n;
      int          ncyc;
      pin = {2'b00, a[21:0]};
      if (sp == sp_rom) pin = {10'h0, a[13:0]};
      if (sp == sp_ram) pin = {14'h0, a[9:0]};
      if (sp == sp_peri) pin = {15'h0, a[8:0]};
      if (sp == sp_dram && mux_on) pin = {12'h000, a[23:12]};
      sel = (sp == sp_ext || sp == sp_mux) ? ~(8'h01 << a[26:24]) : 8'hff;
      ncyc = (sp == sp_dram && mux_on) ? 2 : 1 + int'(lw);
      @(posedge mclk_i);
      acc_req_i <= 1'b1;
      acc_addr_i <= a;
      @(posedge mclk_i);
      acc_req_i <= 1'b0;
      #1;
      check(area_select_n_o, sel);
      check(space_o, sp);
      check(bus_width_o, w);
      check(long_wait_states_o, lw);
      check(pin_addr_o, pin);
      check(acc_ready_o, 1'b0);
      check(dram_col_phase_o, 1'b0);
      n = 1;
      while (cycle_done_o !== 1'b1 && n < 8) begin
         @(posedge mclk_i);
         #1;
         n++;
      end
      check(n, ncyc);
      if (sp == sp_dram && mux_on) begin
         check(dram_col_phase_o, 1'b1);
         check(pin_addr_o, {12'h000, a[11:0]});
      end
      check(area_select_n_o, sel);
      @(posedge mclk_i);
      #1;
      check(area_select_n_o, 8'hff);
      check(acc_ready_o, 1'b1);
      // The partner registers the select one edge late, so look only now.
      if (sel != 8'hff) check(last_area, a[26:24]);
   endtask : acc

   task automatic stop_test();
      $display("compared %0d, wrong %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test

   initial begin
      #40000;
      n_fail++;
      stop_test();
   end

   initial begin
      repeat (6) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      #1;
      check(area_select_n_o, 8'hff);
      reg_read(4'h0, 8'h00);
      reg_read(4'h4, 8'h00);
      reg_read(4'h8, 8'h0f);
      reg_write(4'hc, 8'hff);
      reg_write(4'h2, 8'hff);
      reg_read(4'h2, 8'h00);
      reg_read(4'hc, 8'h00);
      reg_read(4'h8, 8'h0f);
      // Top nibble and A23/A22 set on purpose: both must vanish from the pins.
      acc(32'hf0c12345, sp_ext, w8, 3'd4);
      acc(32'h08c12345, sp_ext, w8, 3'd4);
      set_boot(3'h1);
      acc(32'h00412345, sp_ext, w16, 3'd4);
      acc(32'h08412345, sp_ext, w16, 3'd4);
      set_boot(3'h2);
      acc(32'h00c1f345, sp_rom, w32, 3'd0);
      acc(32'h08c1f345, sp_rom, w32, 3'd0);
      set_boot(3'h0);
      for (int v = 0; v < 4; v++) begin
         reg_write(4'h8, 8'(v | (v << 2)));
         acc(32'h02fa5a5a, sp_ext, w8, 3'(v + 1));
         acc(32'h00fa5a5a, sp_ext, w8, 3'(v + 1));
         acc(32'h06c03000, sp_ext, w8, 3'(v + 1));
      end
      reg_write(4'h8, 8'h06);
      reg_read(4'h8, 8'h06);
      for (int ar = 1; ar < 5; ar++) begin
         for (int h = 0; h < 2; h++) begin
            acc({4'h0, 1'(h), 3'(ar), 24'hc5a5a5}, sp_ext, h ? w16 : w8,
                (ar == 2) ? 3'd3 : 3'd0);
         end
      end
      acc(32'h05fff0a5, sp_peri, w8, 3'd0);
      acc(32'h05fff1a5, sp_peri, w16, 3'd0);
      acc(32'h0dc12345, sp_ext, w16, 3'd0);
      acc(32'h06c04000, sp_ext, w16, 3'd2);
      acc(32'h0ec00000, sp_ext, w16, 3'd2);
      reg_write(4'h0, 8'h02);
      reg_read(4'h0, 8'h02);
      acc(32'h06c04000, sp_mux, w16, 3'd0);
      acc(32'h06c00000, sp_mux, w8, 3'd0);
      acc(32'h0ec00000, sp_ext, w16, 3'd2);
      acc(32'h07c12345, sp_ext, w8, 3'd0);
      acc(32'h0fc12745, sp_ram, w32, 3'd0);
      reg_write(4'h0, 8'h01);
      acc(32'h01c12345, sp_dram, w8, 3'd0);
      acc(32'h09c12345, sp_dram, w16, 3'd0);
      reg_write(4'h4, 8'h01);
      reg_read(4'h4, 8'h01);
      mux_on = 1'b1;
      acc(32'h01c12345, sp_dram, w8, 3'd0);
      check(multi, 1'b0);
      reg_read(4'hc, 8'h04);
      stop_test();
   end
endmodule : test_adcs_area_decode_chip_select
